// *** design/apdu_checker.sv ***
// combinational check of one received frame header
`timescale 1ns/1ps
`default_nettype none
module apdu_checker
   import typeb_pkg::*;
#(
   parameter logic [12:0] MEM_BYTES = 13'd4000,
   parameter logic [7:0]  SEL_P1    = 8'h04,
   parameter logic [7:0]  SEL_P2    = 8'h0c
) (
   frame_if.check f
);
   // ************************************************
   // field decode
   // ************************************************
   wire [7:0] req_afi  = f.hdr[IDX_AFI];
   wire [7:0] cla      = f.hdr[IDX_CLA];
   wire [7:0] ins      = f.hdr[IDX_INS];
   wire [7:0] p1       = f.hdr[IDX_P1];
   wire [7:0] p2       = f.hdr[IDX_P2];
   wire [7:0] len      = f.hdr[IDX_LEN];
   wire       is_rw    = (ins == INS_READ) || (ins == INS_WRITE);
   wire       is_sel   = (ins == INS_SELECT);
   wire [8:0] data_cnt = f.byte_cnt - 9'(HDR_BYTES);
   // RULE1 any-family request
   wire afi_any   = (req_afi == AFI_ANY);
   // RULE2 upper nibble match
   wire afi_hi    = (req_afi[3:0] == 4'h0) && (req_afi[7:4] == f.stored_afi[7:4]);
   // RULE3 lower nibble match
   wire afi_lo    = (req_afi[7:4] == 4'h0) && (req_afi[3:0] == f.stored_afi[3:0]);
   // RULE4 exact byte match
   wire afi_exact = (req_afi[7:4] != 4'h0) && (req_afi[3:0] != 4'h0)
                    && (req_afi == f.stored_afi);
   assign f.is_reqb   = (cla == CMD_REQB);
   assign f.afi_match = f.is_reqb && (afi_any || afi_hi || afi_lo || afi_exact);
   // RULE9 mode bits decode
   assign f.mode      = p1[6:4];
   assign f.tunnel    = p1[6];
   assign f.enc       = p1[5];
   // RULE7 address from p1 p2
   assign f.addr      = {p1[3:0], p2};
   // ************************************************
   // fault detection
   // ************************************************
   // RULE8 top bit rejected
   wire top_bad  = p1[7];
   // RULE10 reserved mode codes
   wire rsv_bad  = p1[4] && !p1[5];
   wire oor_bad  = {1'b0, f.addr} >= MEM_BYTES;
   // RULE11 encrypted address alignment
   wire aln_bad  = f.enc && (f.addr[3:0] != 4'h0);
   // RULE14 encrypted length alignment
   wire elen_bad = f.enc && (len[3:0] != 4'h0 || len < ENC_OVERHEAD);
   wire wlen_bad = (ins == INS_WRITE) && (data_cnt != {1'b0, len});
   wire sel_ok   = (p1 == SEL_P1) && (p2 == SEL_P2);
   // RULE12 plaintext all payload
   // RULE13 iv payload mac layout
   assign f.pay_off = f.enc ? ENC_IV_BYTES : 8'h00;
   assign f.pay_len = f.enc ? 8'(len - ENC_OVERHEAD) : len;
   always_comb begin
      if (cla != CLA_OK) begin
         f.sw = SW_CLA_ERR;
      end else if (is_sel) begin
         // RULE15 matching select answers normally
         f.sw = sel_ok ? SW_OK : SW_P1P2_ERR;
      end else if (!is_rw) begin
         f.sw = SW_INS_ERR;
      // RULE16 p1 p2 faults
      end else if (top_bad || rsv_bad || oor_bad || aln_bad) begin
         f.sw = SW_P1P2_ERR;
      // RULE17 length faults
      end else if (elen_bad || wlen_bad) begin
         f.sw = SW_LEN_ERR;
      end else begin
         f.sw = SW_OK;
      end
   end
endmodule
`default_nettype wire

// *** design/typeb_apdu_parameter_decoder.sv ***
// type b frame receiver, parameter decoder and register slave
//
// How it works
// RULE1 - afi 0x00 always answers
// RULE2 - afi 0xY0 compares upper nibble
// RULE3 - afi 0x0Y compares lower nibble
// RULE4 - other afi needs exact match
// RULE5 - pupi is low four identifier bytes
// RULE6 - wait limit is T times 2^fwi
// RULE7 - address comes from p1 and p2
// RULE8 - p1 top bit set is rejected
// RULE9 - p1 bits 6..4 select link, cipher
// RULE10 - reserved mode codes give error
// RULE11 - encrypted addresses sixteen byte aligned
// RULE12 - plaintext data is all payload
// RULE13 - encrypted: iv, payload, mac blocks
// RULE14 - encrypted length must be sixteen multiple
// RULE15 - matching select gets normal completion
// RULE16 - p1 p2 faults answer 6a86
// RULE17 - length faults answer 6700
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module typeb_apdu_parameter_decoder
   import typeb_pkg::*;
#(
   parameter int          FWT_T_CYCLES = FWT_T_NS * CLK_MHZ / 1000,
   parameter logic [12:0] MEM_BYTES    = 13'd4000,
   parameter logic [7:0]  SEL_P1       = 8'h04,
   parameter logic [7:0]  SEL_P2       = 8'h0c
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        link_clk,
   input  wire logic        link_frame,
   input  wire logic        link_data,
   output logic             reqb_answer,
   output logic             fwt_expired,
   output logic             irq
);
   // ************************************************
   // ahb address phase capture
   // ************************************************
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] rdata_q;
   wire         ahb_go   = hsel && htrans[1] && hready;
   wire         ahb_rd   = ahb_go && !hwrite;
   wire [7:0]   ahb_off  = haddr[7:0];
   wire         wr_ctrl  = wr_pend_q && (wr_addr_q == REG_CTRL);
   wire         wr_afi   = wr_pend_q && (wr_addr_q == REG_AFI);
   wire         wr_idlo  = wr_pend_q && (wr_addr_q == REG_ID_LO);
   wire         wr_idhi  = wr_pend_q && (wr_addr_q == REG_ID_HI);
   wire         wr_stat  = wr_pend_q && (wr_addr_q == REG_INT_STAT);
   wire         wr_mask  = wr_pend_q && (wr_addr_q == REG_INT_MASK);
   wire         wr_resp  = wr_pend_q && (wr_addr_q == REG_RESP);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= ahb_go && hwrite && (haddr[31:8] == 24'h000000);
         wr_addr_q <= ahb_off;
      end
   end

   // ************************************************
   // software registers
   // ************************************************
   logic [3:0]          fwi_q;
   logic [7:0]          afi_q;
   logic [63:0]         sysid_q;
   logic [INT_BITS-1:0] mask_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwi_q   <= FWI_RESET;
         afi_q   <= AFI_RESET;
         sysid_q <= 64'h0000000000000000;
         mask_q  <= '0;
      end else begin
         if (wr_ctrl) begin
            fwi_q <= (hwdata[3:0] > 4'(FWI_MAX)) ? 4'(FWI_MAX) : hwdata[3:0];
         end
         if (wr_afi) begin
            afi_q <= hwdata[7:0];
         end
         if (wr_idlo) begin
            sysid_q[31:0] <= hwdata;
         end
         if (wr_idhi) begin
            sysid_q[63:32] <= hwdata;
         end
         if (wr_mask) begin
            mask_q <= hwdata[INT_BITS-1:0];
         end
      end
   end

   // ************************************************
   // link input synchronisers
   // ************************************************
   logic [2:0] clk_s_q;
   logic [2:0] frm_s_q;
   logic [1:0] dat_s_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_s_q <= 3'h0;
         frm_s_q <= 3'h0;
         dat_s_q <= 2'h0;
      end else begin
         clk_s_q <= {clk_s_q[1:0], link_clk};
         frm_s_q <= {frm_s_q[1:0], link_frame};
         dat_s_q <= {dat_s_q[0], link_data};
      end
   end

   wire link_rise  = clk_s_q[1] && !clk_s_q[2];
   wire frame_on   = frm_s_q[1];
   wire frame_beg  = frm_s_q[1] && !frm_s_q[2];
   wire frame_end  = !frm_s_q[1] && frm_s_q[2];
   wire bit_take   = frame_on && link_rise;

   // ************************************************
   // byte assembly, msb first
   // ************************************************
   logic [7:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic [8:0] byte_cnt_q;
   logic [7:0] hdr_q [0:HDR_BYTES-1];
   wire  [7:0] shift_d   = {shift_q[6:0], dat_s_q[1]};
   wire        byte_done = bit_take && (bit_cnt_q == 3'h7);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_q    <= 8'h00;
         bit_cnt_q  <= 3'h0;
         byte_cnt_q <= 9'h000;
      end else if (frame_beg) begin
         bit_cnt_q  <= 3'h0;
         byte_cnt_q <= 9'h000;
      end else if (bit_take) begin
         shift_q   <= shift_d;
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (byte_done && byte_cnt_q != 9'h1ff) begin
            byte_cnt_q <= byte_cnt_q + 9'h001;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < HDR_BYTES; gi++) begin : g_hdr
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               hdr_q[gi] <= 8'h00;
            end else if (frame_beg) begin
               hdr_q[gi] <= 8'h00;
            end else if (byte_done && byte_cnt_q == 9'(gi)) begin
               hdr_q[gi] <= shift_d;
            end
         end
      end
   endgenerate

   // ************************************************
   // header check
   // ************************************************
   frame_if fr ();
   assign fr.hdr        = hdr_q;
   assign fr.byte_cnt   = byte_cnt_q;
   assign fr.stored_afi = afi_q;

   apdu_checker #(
      .MEM_BYTES (MEM_BYTES),
      .SEL_P1    (SEL_P1),
      .SEL_P2    (SEL_P2)
   ) u_check (
      .f (fr.check)
   );

   // ************************************************
   // result capture at frame end
   // ************************************************
   logic [31:0] result_q;
   logic [31:0] xfer_q;
   logic        reqb_q;
   wire         cmd_err  = !fr.is_reqb && (fr.sw != SW_OK);
   wire         is_cmd   = !fr.is_reqb;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_q <= 32'h00000000;
         xfer_q   <= 32'h00000000;
         reqb_q   <= 1'b0;
      end else if (frame_beg) begin
         reqb_q <= 1'b0;
      end else if (frame_end) begin
         // RULE1 answer on afi match
         reqb_q   <= fr.afi_match;
         // RULE16 status word capture
         result_q <= {9'h000, fr.afi_match, fr.is_reqb, fr.tunnel, fr.enc, fr.mode,
                      fr.is_reqb ? 16'h0000 : fr.sw};
         // RULE13 payload window report
         xfer_q   <= {fr.pay_len, fr.pay_off, 4'h0, fr.addr};
      end
   end
   assign reqb_answer = reqb_q;

   // ************************************************
   // frame waiting timer
   // ************************************************
   logic [31:0] fwt_cnt_q;
   logic        fwt_run_q;
   logic        fwt_exp_q;
   wire  [3:0]  fwi_eff   = (fwi_q > 4'(FWI_MAX)) ? 4'(FWI_MAX) : fwi_q;
   // RULE6 limit is base shifted by fwi
   wire  [31:0] fwt_limit = 32'(FWT_T_CYCLES) << fwi_eff;
   wire         fwt_hit   = fwt_run_q && (fwt_cnt_q >= fwt_limit - 32'h1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwt_cnt_q <= 32'h00000000;
         fwt_run_q <= 1'b0;
         fwt_exp_q <= 1'b0;
      end else if (frame_end && is_cmd) begin
         fwt_cnt_q <= 32'h00000000;
         fwt_run_q <= 1'b1;
         fwt_exp_q <= 1'b0;
      end else if (wr_resp || frame_beg) begin
         fwt_run_q <= 1'b0;
      end else if (fwt_hit) begin
         fwt_run_q <= 1'b0;
         fwt_exp_q <= 1'b1;
      end else if (fwt_run_q) begin
         fwt_cnt_q <= fwt_cnt_q + 32'h1;
      end
   end
   assign fwt_expired = fwt_exp_q;

   // ************************************************
   // interrupt status, mask and line
   // ************************************************
   logic [INT_BITS-1:0] stat_q;
   logic                irq_q;
   logic [INT_BITS-1:0] ev_set;
   wire  [INT_BITS-1:0] ev_clr = wr_stat ? hwdata[INT_BITS-1:0] : '0;

   always_comb begin
      ev_set            = '0;
      ev_set[INT_FRAME] = frame_end && is_cmd;
      ev_set[INT_REQB]  = frame_end && fr.afi_match;
      ev_set[INT_ERROR] = frame_end && cmd_err;
      ev_set[INT_FWT]   = fwt_hit;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= '0;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~ev_clr) | ev_set;
         irq_q  <= |(((stat_q & ~ev_clr) | ev_set) & mask_q);
      end
   end
   assign irq = irq_q;

   // ************************************************
   // read data mux
   // ************************************************
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h00000000;
      if (haddr[31:8] == 24'h000000) begin
         unique case (ahb_off)
            REG_CTRL:     rd_mux = {28'h0000000, fwi_q};
            REG_AFI:      rd_mux = {24'h000000, afi_q};
            REG_ID_LO:    rd_mux = sysid_q[31:0];
            REG_ID_HI:    rd_mux = sysid_q[63:32];
            // RULE5 pupi from low identifier bytes
            REG_PUPI:     rd_mux = sysid_q[31:0];
            REG_RESULT:   rd_mux = result_q;
            REG_XFER:     rd_mux = xfer_q;
            REG_INT_STAT: rd_mux = {28'h0000000, stat_q};
            REG_INT_MASK: rd_mux = {28'h0000000, mask_q};
            default:      rd_mux = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h00000000;
      end else if (ahb_rd) begin
         rdata_q <= rd_mux;
      end
   end
endmodule
`default_nettype wire

// *** pkg/frame_if.sv ***
// header bytes out to the checker and its verdict back
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
   logic [7:0]  hdr [0:4];
   logic [8:0]  byte_cnt;
   logic [7:0]  stored_afi;
   logic        is_reqb;
   logic        afi_match;
   logic [15:0] sw;
   logic [2:0]  mode;
   logic        enc;
   logic        tunnel;
   logic [11:0] addr;
   logic [7:0]  pay_off;
   logic [7:0]  pay_len;
   modport owner (output hdr, byte_cnt, stored_afi,
                  input  is_reqb, afi_match, sw, mode, enc, tunnel, addr, pay_off, pay_len);
   modport check (input  hdr, byte_cnt, stored_afi,
                  output is_reqb, afi_match, sw, mode, enc, tunnel, addr, pay_off, pay_len);
endinterface
`default_nettype wire

// *** pkg/typeb_pkg.sv ***
// shared constants for the type b parameter decoder
package typeb_pkg;
   // ************************************************
   // clock and timing
   // ************************************************
   localparam int          CLK_MHZ          = 25;
   localparam int          FWT_T_NS         = 302000;
   localparam int          FWI_MAX          = 14;
   // ************************************************
   // frame layout and codes
   // ************************************************
   localparam int          HDR_BYTES        = 5;
   localparam int          IDX_CLA          = 0;
   localparam int          IDX_INS          = 1;
   localparam int          IDX_P1           = 2;
   localparam int          IDX_P2           = 3;
   localparam int          IDX_LEN          = 4;
   localparam int          IDX_AFI          = 1;
   localparam logic [7:0]  CMD_REQB         = 8'h05;
   localparam logic [7:0]  CLA_OK           = 8'h00;
   localparam logic [7:0]  INS_SELECT       = 8'ha4;
   localparam logic [7:0]  INS_READ         = 8'hb0;
   localparam logic [7:0]  INS_WRITE        = 8'hd6;
   localparam logic [7:0]  AFI_ANY          = 8'h00;
   localparam logic [7:0]  ENC_BLOCK        = 8'h10;
   localparam logic [7:0]  ENC_IV_BYTES     = 8'h10;
   localparam logic [7:0]  ENC_OVERHEAD     = 8'h20;
   // ************************************************
   // status words
   // ************************************************
   localparam logic [15:0] SW_OK            = 16'h9000;
   localparam logic [15:0] SW_LEN_ERR       = 16'h6700;
   localparam logic [15:0] SW_P1P2_ERR      = 16'h6a86;
   localparam logic [15:0] SW_INS_ERR       = 16'h6d00;
   localparam logic [15:0] SW_CLA_ERR       = 16'h6e00;
   // ************************************************
   // register offsets
   // ************************************************
   localparam logic [7:0]  REG_CTRL         = 8'h00;
   localparam logic [7:0]  REG_AFI          = 8'h04;
   localparam logic [7:0]  REG_ID_LO        = 8'h08;
   localparam logic [7:0]  REG_ID_HI        = 8'h0c;
   localparam logic [7:0]  REG_PUPI         = 8'h10;
   localparam logic [7:0]  REG_RESULT       = 8'h14;
   localparam logic [7:0]  REG_XFER         = 8'h18;
   localparam logic [7:0]  REG_INT_STAT     = 8'h1c;
   localparam logic [7:0]  REG_INT_MASK     = 8'h20;
   localparam logic [7:0]  REG_RESP         = 8'h24;
   // ************************************************
   // fields and reset values
   // ************************************************
   localparam logic [3:0]  FWI_RESET        = 4'h0;
   localparam logic [7:0]  AFI_RESET        = 8'h00;
   localparam int          INT_BITS         = 4;
   localparam int          INT_FRAME        = 0;
   localparam int          INT_REQB         = 1;
   localparam int          INT_ERROR        = 2;
   localparam int          INT_FWT          = 3;
   localparam int          RES_MODE_LSB     = 16;
   localparam int          RES_ENC          = 19;
   localparam int          RES_TUNNEL       = 20;
   localparam int          RES_REQB         = 21;
   localparam int          RES_AFI_HIT      = 22;
   localparam int          XFER_OFF_LSB     = 16;
   localparam int          XFER_LEN_LSB     = 24;
endpackage

// *** verification/rf_reader.sv ***
// reader model driving frames onto the link
`timescale 1ns/1ps
`default_nettype none
module rf_reader (
   output logic link_clk,
   output logic link_frame,
   output logic link_data
);
   initial begin
      link_clk   = 1'b0;
      link_frame = 1'b0;
      link_data  = 1'b1;
   end
   task automatic send(input logic [7:0] b [0:15], input int cnt);
      #13 link_frame = 1'b1;
      for (int i = 0; i < cnt * 8; i++) begin
         #80 link_data = b[i / 8][7 - i % 8];
         #80 link_clk = 1'b1;
         #160 link_clk = 1'b0;
      end
      #80 link_frame = 1'b0;
      link_data = ~link_data;
   endtask
endmodule
`default_nettype wire

// *** verification/typeb_apdu_parameter_decoder_tb.sv ***
// self-checking bench for the type b parameter decoder
`timescale 1ns/1ps
`default_nettype none
module typeb_apdu_parameter_decoder_tb
   import typeb_pkg::*;
;
   localparam int T_CYC = 10;
   typedef struct {
      string       name;
      logic [31:0] exp;
      logic [31:0] mask;
      int          src;
   } note_type;
   logic        hclk, hresetn, hsel, hwrite, rd_phase, flag_phase, fwt_ok, hit;
   logic [31:0] haddr, hwdata, id;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  fb [0:15];
   logic [7:0]  ins, p1, p2, ln, nd, st, rq;
   logic [15:0] sw;
   logic [55:0] cmd_tab [0:15];
   wire         hready, hresp, reqb_answer, fwt_expired, irq, link_clk, link_frame, link_data;
   wire  [31:0] hrdata;
   wire  [3:0]  flags = {fwt_ok, irq, reqb_answer, 1'b0};
   integer      n_fail, comparisons, cycles, seed, n;
   note_type    notes [$];
   note_type    cur;
   typeb_apdu_parameter_decoder #(.FWT_T_CYCLES(T_CYC)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
      .link_frame(link_frame), .link_data(link_data), .reqb_answer(reqb_answer),
      .fwt_expired(fwt_expired), .irq(irq));
   rf_reader rdr (.link_clk(link_clk), .link_frame(link_frame), .link_data(link_data));
   // ************************************************
   // clock, timeout, compares, verdict
   // ************************************************
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_fail = n_fail + 1;
         wrap_up();
      end
   end
   task automatic cmp_word(input string nm, input logic [31:0] e, g, m);
      comparisons++;
      if ((g & m) !== (e & m)) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e & m, g & m);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic e, g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge hclk) begin
      if (rd_phase || flag_phase) begin
         cur = notes.pop_front();
         if (cur.src == 0) cmp_word(cur.name, cur.exp, hrdata, cur.mask);
         else cmp_bit(cur.name, cur.exp[0], flags[cur.src]);
      end
   end
   // ************************************************
   // drivers
   // ************************************************
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel     <= 1'b0;
      htrans   <= 2'b00;
      hwdata   <= d;
      rd_phase <= !w;
      do @(posedge hclk); while (hready !== 1'b1);
      rd_phase <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, {24'h0, a}, d);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, m);
      notes.push_back('{nm, e, m, 0});
      bus(1'b0, {24'h0, a}, 32'h0);
   endtask
   task automatic flag(input string nm, input int s, input logic e);
      notes.push_back('{nm, {31'h0, e}, 32'h1, s});
      @(posedge hclk);
      flag_phase <= 1'b1;
      @(posedge hclk);
      flag_phase <= 1'b0;
   endtask
   task automatic frame(input int cnt);
      rdr.send(fb, cnt);
      repeat (12) @(posedge hclk);
   endtask
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      seed = 75;
      n_fail = 0;
      comparisons = 0;
      cycles = 0;
      {hresetn, hsel, hwrite, rd_phase, flag_phase, fwt_ok} = 6'h00;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
      // ins p1 p2 len data status
      cmd_tab = '{56'hb00f9f05009000, 56'hb0201030009000, 56'hb0312020009000,
         56'hb0400501009000, 56'hb0600030009000, 56'hb0703040009000, 56'hb0100001006a86,
         56'hb0500001006a86, 56'hb0800001006a86, 56'hb0200820006a86, 56'hb0200028006700,
         56'hb00fa001006a86, 56'ha4040c00009000, 56'ha4040000006a86, 56'hd6000202029000,
         56'hd6000203026700};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd("ctrl", REG_CTRL, {28'h0, FWI_RESET}, 32'hffffffff);
      rd("afi", REG_AFI, {24'h0, AFI_RESET}, 32'hffffffff);
      notes.push_back('{"unmapped", 32'h0, 32'hffffffff, 0});
      bus(1'b0, 32'h100, 32'h0);
      wr(REG_CTRL, 32'hf);
      rd("fwi clip", REG_CTRL, 32'he, 32'hf);
      id = $random(seed);
      wr(REG_ID_LO, id);
      wr(REG_ID_HI, ~id);
      rd("pupi", REG_PUPI, id, 32'hffffffff);
      for (int i = 0; i < 12; i++) begin
         st = 8'($random(seed));
         case (i % 4)
            0: rq = 8'h00;
            1: rq = {st[7:4] ^ {3'b0, i[2]}, 4'h0};
            2: rq = {4'h0, st[3:0] ^ {3'b0, i[2]}};
            default: rq = i[2] ? st : st ^ 8'h01;
         endcase
         hit = rq == 8'h00 || (rq[3:0] == 4'h0 && rq[7:4] == st[7:4]) ||
               (rq[7:4] == 4'h0 && rq[3:0] == st[3:0]) || rq == st;
         wr(REG_AFI, {24'h0, st});
         fb = '{0: CMD_REQB, 1: rq, default: 8'h00};
         frame(3);
         flag("reqb answer", 1, hit);
         rd("afi hit", REG_RESULT, {9'h0, hit, 1'b1, 21'h0}, 32'h600000);
      end
      for (int i = 0; i < 16; i++) begin
         {ins, p1, p2, ln, nd, sw} = cmd_tab[i];
         fb = '{0: CLA_OK, 1: ins, 2: p1, 3: p2, 4: ln, default: 8'h00};
         for (int k = 0; k < nd; k++) fb[5 + k] = 8'($random(seed));
         frame(5 + nd);
         rd("result", REG_RESULT, {11'h0, p1[6:5], p1[6:4], sw},
            sw == SW_OK ? 32'h1fffff : 32'hffff);
         if (sw == SW_OK && ins != INS_SELECT)
            rd("xfer", REG_XFER, {p1[5] ? ln - 8'h20 : ln, p1[5] ? ENC_BLOCK : 8'h00,
               4'h0, p1[3:0], p2}, 32'hffff0fff);
      end
      rd("int stat", REG_INT_STAT, 32'h7, 32'hf);
      flag("irq masked", 2, 1'b0);
      wr(REG_INT_MASK, 32'h4);
      flag("irq raised", 2, 1'b1);
      wr(REG_INT_STAT, 32'h4);
      flag("irq cleared", 2, 1'b0);
      rd("int stat", REG_INT_STAT, 32'h3, 32'hf);
      wr(REG_RESP, 32'h0);
      wr(REG_CTRL, 32'h2);
      fb = '{0: CLA_OK, 1: INS_READ, 4: 8'h01, default: 8'h00};
      rdr.send(fb, 5);
      n = 0;
      while (fwt_expired !== 1'b1 && n < 200) begin
         @(posedge hclk);
         n++;
      end
      fwt_ok = n >= T_CYC * 4 && n <= T_CYC * 4 + 8;
      flag("fwt window", 3, 1'b1);
      rd("fwt status", REG_INT_STAT, 32'h8, 32'h8);
      wr(REG_INT_MASK, 32'h8);
      flag("fwt irq", 2, 1'b1);
      wrap_up();
   end
endmodule
bind typeb_apdu_parameter_decoder typeb_sva #(.FWT_T_CYCLES(FWT_T_CYCLES)) sva_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
   .link_frame(link_frame), .link_data(link_data), .reqb_answer(reqb_answer),
   .fwt_expired(fwt_expired), .irq(irq));
`default_nettype wire

// *** verification/typeb_sva.sv ***
// concurrent checks on the decoder's top-level ports
`timescale 1ns/1ps
`default_nettype none
module typeb_sva
   import typeb_pkg::*;
#(
   parameter int FWT_T_CYCLES = 10
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        link_clk,
   input wire logic        link_frame,
   input wire logic        link_data,
   input wire logic        reqb_answer,
   input wire logic        fwt_expired,
   input wire logic        irq
);
   // ************************************************
   // helper state
   // ************************************************
   wire         take    = hsel && htrans[1] && hready;
   wire         rd_take = take && !hwrite;
   logic [31:0] quiet_q;
   logic [31:0] id_lo_q;
   logic [3:0]  mask_q;
   logic [7:0]  wreg_q;
   logic        wr_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quiet_q <= 32'h0;
         id_lo_q <= 32'h0;
         mask_q  <= 4'h0;
         wreg_q  <= 8'h00;
         wr_q    <= 1'b0;
      end else begin
         quiet_q <= link_frame ? 32'h0 : quiet_q + 32'h1;
         wr_q    <= take && hwrite;
         wreg_q  <= haddr[7:0];
         if (wr_q && wreg_q == REG_ID_LO) id_lo_q <= hwdata;
         if (wr_q && wreg_q == REG_INT_MASK) mask_q <= hwdata[3:0];
      end
   end
   // ************************************************
   // assertions
   // ************************************************
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_always:
      assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay:
      assert property (!hresp) else $error("hresp not okay");
   a_pupi_id_low:
      assert property (rd_take && haddr == {24'h0, REG_PUPI} |=> hrdata == id_lo_q)
      else $error("pupi differs from id low word");
   a_read_hold:
      assert property ($changed(hrdata) |-> $past(rd_take))
      else $error("hrdata changed without a read");
   a_reqb_clear:
      assert property ($rose(link_frame) |-> ##[1:6] !reqb_answer)
      else $error("reqb answer not cleared at frame start");
   a_reqb_after_end:
      assert property ($rose(reqb_answer) |-> !link_frame && $past(link_frame, 2) == 1'b0)
      else $error("reqb answer rose inside a frame");
   a_fwt_wait:
      assert property ($rose(fwt_expired) |-> quiet_q >= FWT_T_CYCLES)
      else $error("wait timer expired too early");
   a_irq_masked:
      assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
      else $error("irq high with all masked");
endmodule
`default_nettype wire
